/* File: design/lfs_consts.svh */
// offsets, field positions, reset values and widths of the led fault status word
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_IDX_FAULT_STATUS 12'h0012
`define LFS_ADDR_FAULT_STATUS 12'h0048
`define LFS_RESET_WORD 16'h0000
`define LFS_WORD_W 16
`define LFS_NUM_CH 4
`define LFS_BIT_SPARE 15
`define LFS_BIT_BUS_TIMEOUT_FLAG 14
`define LFS_BIT_BUS_TIMEOUT_CLEAR 13
`define LFS_BIT_BAD_STRING_FLAG 12
`define LFS_BIT_BAD_STRING_CLEAR 11
`define LFS_BIT_SUMMARY_FLAG 10
`define LFS_BIT_SUMMARY_CLEAR 9
`define LFS_BIT_GROUND_SHORT 8
`define LFS_BIT_INTERNAL_SHORT 7
`define LFS_BIT_OPEN_STRING 6
`define LFS_BIT_KEEP_ZERO 5
`endif

/* File: design/lfs_pkg.sv */
// types shared by the led fault status block
package lfs_pkg;
   typedef logic [15:0] lfs_word_t;
   typedef logic [11:0] lfs_addr_t;
   typedef logic [31:0] lfs_data_t;
   typedef enum logic [1:0] {
      LFS_IDLE,
      LFS_ANSWER
   } lfs_apb_e;
endpackage

/* File: design/lfs_status.sv */
// led fault status word with apb slave access
//
// Behaviour
// RQ1: the status word sits at register index 12h (byte address 48h) and reads all zero after reset.
// RQ2: bit 14 is set by a serial bus timeout fault and reads zero while no such fault was seen.
// RQ3: writing 1 to a latched flag and its clear bit together drops the flag and the fault pin indication.
// RQ4: bit 13 is the clear bit paired with the bus timeout flag in bit 14.
// RQ5: bit 12 is set by an invalid string configuration and bit 11 is its clear bit.
// RQ6: bit 10 is set by any open, internal short or ground short fault and bit 9 is its clear bit.
// RQ7: bit 8 is a read-only ground short indication, 1 meaning fault.
// RQ8: bit 7 is a read-only internal short flag that clears only with the summary flag.
// RQ9: bit 6 is a read-only open string flag that clears together with the summary flag.
// RQ10: bits 3 to 0 are read-only per-channel fault flags, zero after reset.
// RQ11: software always writes zero to reserved bit 5.
// RQ12: bit 15 is a spare read-write bit with no function, zero after reset.
// RQ13: a clear bit written without its paired status bit leaves the flag latched.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "lfs_consts.svh"

module lfs_status #(
   parameter int NUM_CH = `LFS_NUM_CH
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire lfs_pkg::lfs_addr_t paddr,
   input wire lfs_pkg::lfs_data_t pwdata,
   input wire logic [3:0] pstrb,
   output lfs_pkg::lfs_data_t prdata,
   output logic pready,
   output logic pslverr,
   // fault detector events, one-cycle pulses or levels
   input wire logic bus_timeout_evt,
   input wire logic bad_string_evt,
   input wire logic open_string_evt,
   input wire logic internal_short_evt,
   input wire logic ground_short_in,
   input wire logic [NUM_CH-1:0] channel_fault_in,
   // fault pin indication
   output logic fault_ind
);
   import lfs_pkg::*;

   // only four channel bits exist below the reserved pair, refuse more at elaboration
   generate
      if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
         $error("lfs_status: NUM_CH must lie in 1..4");
      end
   endgenerate

   // bus state
   lfs_apb_e state_r;
   lfs_apb_e state_nxt;
   lfs_data_t prdata_r;
   logic pready_r;
   logic pslverr_r;

   // register contents
   logic spare_r;
   logic bus_timeout_flag_r;
   logic bad_string_flag_r;
   logic summary_flag_r;
   logic ground_short_r;
   logic internal_short_r;
   logic open_string_r;
   logic [NUM_CH-1:0] channel_fault_r;
   logic fault_ind_r;

   // decode
   logic hit;
   logic wr_commit;
   logic clr_timeout;
   logic clr_bad_string;
   logic clr_summary;
   logic any_led_evt;
   lfs_word_t word_view;

   assign hit = (paddr == `LFS_ADDR_FAULT_STATUS); // RQ1
   // writes land only at the edge where the master sees pready
   assign wr_commit = psel && penable && pready_r && pwrite && hit && pstrb[1];
   // both the flag bit and its clear bit must be 1 in the same write
   assign clr_timeout = wr_commit && pwdata[`LFS_BIT_BUS_TIMEOUT_FLAG]
                        && pwdata[`LFS_BIT_BUS_TIMEOUT_CLEAR]; // RQ3 RQ4 RQ13
   assign clr_bad_string = wr_commit && pwdata[`LFS_BIT_BAD_STRING_FLAG]
                           && pwdata[`LFS_BIT_BAD_STRING_CLEAR]; // RQ3 RQ5 RQ13
   assign clr_summary = wr_commit && pwdata[`LFS_BIT_SUMMARY_FLAG]
                        && pwdata[`LFS_BIT_SUMMARY_CLEAR]; // RQ3 RQ6 RQ13
   assign any_led_evt = open_string_evt || internal_short_evt || ground_short_in; // RQ6

   always_comb begin
      word_view = `LFS_RESET_WORD;
      word_view[`LFS_BIT_SPARE] = spare_r; // RQ12
      word_view[`LFS_BIT_BUS_TIMEOUT_FLAG] = bus_timeout_flag_r; // RQ2
      word_view[`LFS_BIT_BAD_STRING_FLAG] = bad_string_flag_r; // RQ5
      word_view[`LFS_BIT_SUMMARY_FLAG] = summary_flag_r; // RQ6
      word_view[`LFS_BIT_GROUND_SHORT] = ground_short_r; // RQ7
      word_view[`LFS_BIT_INTERNAL_SHORT] = internal_short_r; // RQ8
      word_view[`LFS_BIT_OPEN_STRING] = open_string_r; // RQ9
      word_view[NUM_CH-1:0] = channel_fault_r; // RQ10
   end

   // one wait state: access phase, then answer cycle
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         LFS_IDLE: begin
            if (psel && penable) begin
               state_nxt = LFS_ANSWER;
            end
         end
         LFS_ANSWER: begin
            state_nxt = LFS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= LFS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (state_r == LFS_IDLE && psel && penable) begin
         pready_r <= 1'b1;
         pslverr_r <= !hit;
         // unmapped reads answer zero with an error
         prdata_r <= (hit && !pwrite) ? {16'h0000, word_view} : 32'h0000_0000;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
   end

   // spare bit stores, bit 5 write is dropped on purpose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spare_r <= 1'b0;
      end else if (wr_commit) begin
         spare_r <= pwdata[`LFS_BIT_SPARE]; // RQ12
      end
   end

   // sticky flags: a new event in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_timeout_flag_r <= 1'b0;
      end else if (bus_timeout_evt) begin
         bus_timeout_flag_r <= 1'b1; // RQ2
      end else if (clr_timeout) begin
         bus_timeout_flag_r <= 1'b0; // RQ3
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_string_flag_r <= 1'b0;
      end else if (bad_string_evt) begin
         bad_string_flag_r <= 1'b1; // RQ5
      end else if (clr_bad_string) begin
         bad_string_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         summary_flag_r <= 1'b0;
      end else if (any_led_evt) begin
         summary_flag_r <= 1'b1; // RQ6
      end else if (clr_summary) begin
         summary_flag_r <= 1'b0;
      end
   end

   // detail flags follow the summary clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_short_r <= 1'b0;
         open_string_r <= 1'b0;
      end else begin
         if (internal_short_evt) begin
            internal_short_r <= 1'b1;
         end else if (clr_summary) begin
            internal_short_r <= 1'b0; // RQ8
         end
         if (open_string_evt) begin
            open_string_r <= 1'b1;
         end else if (clr_summary) begin
            open_string_r <= 1'b0; // RQ9
         end
      end
   end

   // ground short is a live level, sampled every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ground_short_r <= 1'b0;
      end else begin
         ground_short_r <= ground_short_in; // RQ7
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               channel_fault_r[ch] <= 1'b0;
            end else begin
               channel_fault_r[ch] <= channel_fault_in[ch]; // RQ10
            end
         end
      end
   endgenerate

   // pin indication mirrors the next value of the latched flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_ind_r <= 1'b0;
      end else begin
         fault_ind_r <= (bus_timeout_evt || (bus_timeout_flag_r && !clr_timeout))
                        || (bad_string_evt || (bad_string_flag_r && !clr_bad_string))
                        || (any_led_evt || (summary_flag_r && !clr_summary)); // RQ3
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign fault_ind = fault_ind_r;

   a_timeout_sets: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      bus_timeout_evt |=> bus_timeout_flag_r)
      else $error("timeout event did not set flag");

   a_timeout_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      clr_timeout && !bus_timeout_evt |=> !bus_timeout_flag_r)
      else $error("paired write did not clear timeout flag");

   a_lone_clear_kept: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      wr_commit && pwdata[`LFS_BIT_SUMMARY_CLEAR] && !pwdata[`LFS_BIT_SUMMARY_FLAG]
      && summary_flag_r |=> summary_flag_r)
      else $error("lone clear bit dropped summary flag");

   a_pin_drops: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (bus_timeout_flag_r || bad_string_flag_r || summary_flag_r)
      && !bus_timeout_evt && !bad_string_evt && !any_led_evt
      ##1 (!bus_timeout_flag_r && !bad_string_flag_r && !summary_flag_r) |-> !fault_ind)
      else $error("fault pin still set after all flags cleared");

   a_pin_follows: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      fault_ind == (bus_timeout_flag_r || bad_string_flag_r || summary_flag_r))
      else $error("fault pin differs from latched flags");

   a_string_sets: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      bad_string_evt |=> bad_string_flag_r && fault_ind)
      else $error("string event did not set flag and pin");

   a_summary_any: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      (open_string_evt || internal_short_evt || ground_short_in) |=> summary_flag_r)
      else $error("led fault did not set summary flag");

   a_detail_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      internal_short_r && !clr_summary |=> internal_short_r)
      else $error("internal short flag cleared without summary clear");

   a_open_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
      clr_summary && !open_string_evt |=> !open_string_r && !summary_flag_r)
      else $error("open flag did not clear with summary");

   a_ground_live: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      ground_short_in |=> ground_short_r)
      else $error("ground short not reported");

   a_chan_track: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      ##1 channel_fault_r == $past(channel_fault_in))
      else $error("channel flags do not track inputs");

   a_read_word: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      state_r == LFS_IDLE && psel && penable && !pwrite && hit
      |=> pready && prdata[31:16] == 16'h0000 && !pslverr)
      else $error("read of status word malformed");

   a_spare_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      wr_commit |=> spare_r == $past(pwdata[`LFS_BIT_SPARE]))
      else $error("spare bit did not store write");

   a_event_wins: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      clr_timeout && bus_timeout_evt |=> bus_timeout_flag_r && fault_ind)
      else $error("timeout clear overrode a new event");

   a_string_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      clr_bad_string && !bad_string_evt |=> !bad_string_flag_r)
      else $error("paired write did not clear string flag");

endmodule

/* File: tb/lfs_status_tb.sv */
// self-checking testbench for the led fault status word
`timescale 1ns/1ns
`include "lfs_consts.svh"

module lfs_status_tb;
   import lfs_pkg::*;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   lfs_addr_t paddr = '0;
   lfs_data_t pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   lfs_data_t prdata;
   logic pready;
   logic pslverr;
   logic [3:0] ev = 4'h0;
   logic ground_short_in = 1'b0;
   logic [3:0] channel_fault_in = 4'h0;
   logic fault_ind;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   lfs_data_t rd;
   logic err;

   lfs_status DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_timeout_evt(ev[0]), .bad_string_evt(ev[1]),
      .open_string_evt(ev[2]), .internal_short_evt(ev[3]), .ground_short_in(ground_short_in),
      .channel_fault_in(channel_fault_in), .fault_ind(fault_ind)
   );

   always #10 pclk = ~pclk;

   task automatic test_done();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // runaway guard, the whole sequence needs well under a thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic chk(input string what, input lfs_data_t seen, input lfs_data_t exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer, entered just after a rising edge, leaves one idle edge behind
   task automatic apb(input logic wr, input lfs_addr_t a, input lfs_data_t d, input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input lfs_data_t d);
      apb(1'b1, `LFS_ADDR_FAULT_STATUS, d, 4'hf);
   endtask

   task automatic rd_chk(input string what, input lfs_data_t exp);
      apb(1'b0, `LFS_ADDR_FAULT_STATUS, 32'h0000_0000, 4'h0);
      chk(what, rd, exp);
      chk("slverr", {31'h0000_0000, err}, 32'h0000_0000);
   endtask

   // one-cycle event pulses on the selected detector inputs
   task automatic pulse(input logic [3:0] m);
      ev <= m;
      @(posedge pclk);
      ev <= 4'h0;
      @(posedge pclk);
   endtask

   task automatic ind_chk(input logic exp);
      chk("fault_ind", {31'h0000_0000, fault_ind}, {31'h0000_0000, exp});
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk("reset word", 32'h0000_0000);
      ind_chk(1'b0);
      pulse(4'h1);
      rd_chk("timeout set", 32'h0000_4000);
      ind_chk(1'b1);
      wr(32'h0000_2000);
      rd_chk("clear bit alone", 32'h0000_4000);
      wr(32'h0000_4000);
      rd_chk("flag bit alone", 32'h0000_4000);
      // new event lands on the clearing edge, the event must win
      fork
         wr(32'h0000_6000);
         begin
            repeat (2) @(posedge pclk);
            ev <= 4'h1;
            @(posedge pclk);
            ev <= 4'h0;
         end
      join
      rd_chk("event beats clear", 32'h0000_4000);
      ind_chk(1'b1);
      wr(32'h0000_6000);
      rd_chk("timeout cleared", 32'h0000_0000);
      ind_chk(1'b0);
      pulse(4'h2);
      rd_chk("bad string set", 32'h0000_1000);
      wr(32'h0000_0800);
      rd_chk("bad string clear alone", 32'h0000_1000);
      wr(32'h0000_1800);
      rd_chk("bad string cleared", 32'h0000_0000);
      ind_chk(1'b0);
      ground_short_in <= 1'b1;
      channel_fault_in <= 4'ha;
      pulse(4'hc);
      rd_chk("led faults", 32'h0000_05ca);
      ind_chk(1'b1);
      ground_short_in <= 1'b0;
      channel_fault_in <= 4'h5;
      @(posedge pclk);
      @(posedge pclk);
      rd_chk("live copies", 32'h0000_04c5);
      wr(32'h0000_0200);
      rd_chk("summary clear alone", 32'h0000_04c5);
      channel_fault_in <= 4'h0;
      wr(32'h0000_0600);
      rd_chk("summary cleared", 32'h0000_0000);
      ind_chk(1'b0);
      // bit 5 always written as zero by software
      wr(32'h0000_01df);
      rd_chk("read-only bits", 32'h0000_0000);
      wr(32'h0000_8000);
      rd_chk("spare bit", 32'h0000_8000);
      apb(1'b1, `LFS_ADDR_FAULT_STATUS, 32'h0000_0000, 4'h1);
      rd_chk("lane ignored", 32'h0000_8000);
      apb(1'b1, 12'h04c, 32'h0000_0000, 4'hf);
      chk("unmapped wr err", {31'h0000_0000, err}, 32'h0000_0001);
      apb(1'b0, 12'h04c, 32'h0000_0000, 4'h0);
      chk("unmapped rd err", {31'h0000_0000, err}, 32'h0000_0001);
      chk("unmapped rd data", rd, 32'h0000_0000);
      rd_chk("after unmapped", 32'h0000_8000);
      wr(32'h0000_0000);
      rd_chk("spare cleared", 32'h0000_0000);
      // second reset with flags latched and the spare bit set
      wr(32'h0000_8000);
      pulse(4'h7);
      ind_chk(1'b1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      ind_chk(1'b0);
      rd_chk("word after reset", 32'h0000_0000);
      test_done();
   end
endmodule
